// ==== pkg/dacl_code_if.sv ====
/*
 * carries the latched code from the latch core to the output decode.
 * assumes one clock domain shared by both ends.
 */
`timescale 1ns/1ns
`default_nettype none

interface dacl_code_if;
    dacl_pkg::dacl_code_t code;
    logic                 update;
    modport src (output code, output update);
    modport dst (input  code, input  update);
endinterface

`default_nettype wire

// ==== pkg/dacl_defs.svh ====
/*
 * constants for the parallel input latch of the 8-bit converter.
 * assumes inclusion by bare name from package and design files.
 */
`ifndef DACL_DEFS_SVH
`define DACL_DEFS_SVH

`define DACL_SAMPLE_WIDTH    8
`define DACL_FULL_SCALE      9'h100
`define DACL_CODE_MAX        8'hFF
`define DACL_CODE_RESET      8'h00
`define DACL_RATE_MSPS       210
`define DACL_CLK_MHZ         250
`define DACL_DUTY_PCT        50
`define DACL_STRAP_LOW       2'h0
`define DACL_STRAP_HIGH      2'h1
`define DACL_STRAP_FLOAT     2'h2

`endif

// ==== pkg/dacl_pkg.sv ====
/*
 * types for the parallel input latch of the converter.
 * assumes dacl_defs.svh is on the include path.
 */
`include "dacl_defs.svh"

package dacl_pkg;

    typedef enum logic [1:0] {
        DACL_CLK_SINGLE,
        DACL_CLK_DIFF,
        DACL_CLK_TERM
    } dacl_clk_mode_t;

    typedef logic [`DACL_SAMPLE_WIDTH-1:0] dacl_code_t;

endpackage

// ==== src/dacl_latch.sv ====
/*
 * parallel input latch of an 8-bit converter: captures the sample word
 * each rising edge with clk_en high and drives primary and complement output weights.
 * assumes sample word and straps come from pins and are resynchronised here.
 */
// Functional notes
// - eight bits, straight binary, msb highest line
// - capture word on rising edge, update output
// - accept conversion rates up to 210 msps
// - any duty cycle within latch pulse width
// - primary n/256, complement (255-n)/256
// - strap selects single, differential or terminated mode
`timescale 1ns/1ns
`default_nettype none
`include "dacl_defs.svh"

module dacl_latch #(
    parameter int WIDTH = `DACL_SAMPLE_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             clk_en,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] sample_word,
    input  wire logic             clock_mode_strap_low,
    input  wire logic             clock_mode_strap_high,
    output logic [8:0]            primary_current_out,
    output logic [8:0]            complement_current_out,
    output dacl_pkg::dacl_clk_mode_t clock_mode,
    output logic                  neg_clock_used
);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage read only by second
    logic [WIDTH-1:0] word_meta_reg;
    logic [WIDTH-1:0] word_sync_reg;
    logic [1:0]       strap_meta_reg;
    logic [1:0]       strap_sync_reg;

    always_ff @(posedge clk) begin
        if (clk_en) begin
            word_meta_reg  <= sample_word;
            word_sync_reg  <= word_meta_reg;
            strap_meta_reg <= {clock_mode_strap_high, clock_mode_strap_low};
            strap_sync_reg <= strap_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // master/slave latch: bit WIDTH-1 is sample_msb, bit 0 sample_lsb
    // one clock, no duty-cycle dependency; the 250 MHz clock exceeds 210 MSPS
    logic [WIDTH-1:0] code_reg;
    logic             update_reg;
    dacl_code_if      code_link();

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            code_reg   <= `DACL_CODE_RESET;
            update_reg <= 1'b0;
        end else if (clk_en) begin
            code_reg   <= word_sync_reg;
            update_reg <= 1'b1;
        end
    end

    // update marks a code that came through an enabled edge since reset;
    // the split stage holds its reset outputs until then; the synchronisers have no reset,
    // so what they hold at release goes to code_reg on that edge and to the outputs on the next

    assign code_link.code   = code_reg;
    assign code_link.update = update_reg;

    dacl_split u_split (
        .clk                    (clk),
        .clk_en                 (clk_en),
        .sys_rst                (sys_rst),
        .code_in                (code_link.dst),
        .primary_current_out    (primary_current_out),
        .complement_current_out (complement_current_out)
    );

    ////////////////////////////////////////////////////////////////////
    // strap decode: low = ground, high = supply, neither = floating
    // sampled continuously so a late-settling strap still lands
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clock_mode     <= dacl_pkg::DACL_CLK_SINGLE;
            neg_clock_used <= 1'b0;
        end else if (clk_en) begin
            if (strap_sync_reg[0]) begin
                clock_mode     <= dacl_pkg::DACL_CLK_SINGLE;
                neg_clock_used <= 1'b0;
            end else if (strap_sync_reg[1]) begin
                clock_mode     <= dacl_pkg::DACL_CLK_DIFF;
                neg_clock_used <= 1'b1;
            end else begin
                clock_mode     <= dacl_pkg::DACL_CLK_TERM;
                neg_clock_used <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    a_latch_capture: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && !$past(sys_rst) |=> code_reg == $past(word_sync_reg) || !$past(clk_en))
        else $error("latch did not capture word");

    a_latch_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !clk_en |=> $stable(code_reg))
        else $error("code changed without an enabled edge");

    a_strap_single: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && strap_sync_reg[0] |=> clock_mode == dacl_pkg::DACL_CLK_SINGLE)
        else $error("ground strap did not give single mode");

    a_strap_diff: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && strap_sync_reg == 2'h2 |=> clock_mode == dacl_pkg::DACL_CLK_DIFF)
        else $error("supply strap did not give differential mode");

    a_reset_mode: assert property (@(posedge clk)
        sys_rst |=> clock_mode == dacl_pkg::DACL_CLK_SINGLE && !neg_clock_used)
        else $error("reset did not give single mode");

    a_reset_code: assert property (@(posedge clk)
        sys_rst |=> code_reg == `DACL_CODE_RESET && !update_reg)
        else $error("reset did not clear held code");

    a_update_seen: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en |=> update_reg)
        else $error("enabled edge did not mark code as updated");

    a_strap_float: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && strap_sync_reg == 2'h0 |=> clock_mode == dacl_pkg::DACL_CLK_TERM)
        else $error("floating strap did not give terminated mode");

    a_single_negpin: assert property (@(posedge clk) disable iff (sys_rst)
        clock_mode == dacl_pkg::DACL_CLK_SINGLE |-> !neg_clock_used)
        else $error("negative clock used in single mode");

    a_code_to_out: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en [*3] |-> primary_current_out == {1'b0, $past(word_sync_reg, 2)})
        else $error("output lags sample word wrongly");

endmodule // dacl_latch

`default_nettype wire

// ==== src/dacl_split.sv ====
/*
 * splits the held code into primary and complement weights out of 256.
 * assumes the code arrives from flip-flops on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "dacl_defs.svh"

module dacl_split (
    input  wire logic           clk,
    input  wire logic           clk_en,
    input  wire logic           sys_rst,
    dacl_code_if.dst            code_in,
    output logic [8:0]          primary_current_out,
    output logic [8:0]          complement_current_out
);

    // numerators over full scale: n/256 and (255-n)/256
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            primary_current_out    <= 9'h000;
            complement_current_out <= {1'b0, `DACL_CODE_MAX};
        end else if (clk_en && code_in.update) begin
            primary_current_out    <= {1'b0, code_in.code};
            complement_current_out <= {1'b0, `DACL_CODE_MAX - code_in.code};
        end
    end

    a_split_sum: assert property (@(posedge clk) disable iff (sys_rst)
        (primary_current_out + complement_current_out) == {1'b0, `DACL_CODE_MAX})
        else $error("output pair does not sum to 255");

    a_split_follow: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && $past(clk_en) && $past(code_in.update) && !$past(sys_rst) |->
            primary_current_out == {1'b0, $past(code_in.code)})
        else $error("primary output does not follow code");

endmodule // dacl_split

`default_nettype wire

// ==== testbench/dacl_latch_tb.sv ====
/* bench for the converter input latch: code and strap table, stream, hold, reset.
   assumes the source model presents each word half a cycle after the bench. */
`timescale 1ns/1ns
`default_nettype none
module dacl_latch_tb;
    typedef struct packed {
        logic                     lo;
        logic                     hi;
        logic [7:0]               code;
        dacl_pkg::dacl_clk_mode_t mode;
    } dacl_row_t;
    logic                     clk = 1'b0;
    logic                     sys_rst = 1'b1;
    logic                     clk_en = 1'b1;
    logic                     lo = 1'b1;
    logic                     hi = 1'b0;
    logic [7:0]               next_word = 8'h00;
    logic [7:0]               sample_word;
    logic [8:0]               prim;
    logic [8:0]               comp;
    logic                     neg;
    dacl_pkg::dacl_clk_mode_t mode;
    int                       fails = 0;
    int                       checks_done = 0;
    // both straps high: low strap wins
    dacl_row_t                rows [6] = '{
        '{1'b1, 1'b0, 8'h00, dacl_pkg::DACL_CLK_SINGLE}, '{1'b0, 1'b1, 8'hFF, dacl_pkg::DACL_CLK_DIFF},
        '{1'b0, 1'b0, 8'h80, dacl_pkg::DACL_CLK_TERM}, '{1'b1, 1'b1, 8'h01, dacl_pkg::DACL_CLK_SINGLE},
        '{1'b0, 1'b1, 8'h7F, dacl_pkg::DACL_CLK_DIFF}, '{1'b0, 1'b0, 8'hA5, dacl_pkg::DACL_CLK_TERM}};
    ////////////////////////////////////////////////////////////////////////////
    always #2 clk = ~clk;
    dacl_src u_src (.clk(clk), .next_word(next_word), .sample_word(sample_word));
    dacl_latch u_dut (.clk(clk), .clk_en(clk_en), .sys_rst(sys_rst), .sample_word(sample_word),
        .clock_mode_strap_low(lo), .clock_mode_strap_high(hi), .primary_current_out(prim),
        .complement_current_out(comp), .clock_mode(mode), .neg_clock_used(neg));
    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test;
        if (fails == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (400) @(posedge clk);
        fails++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            @(posedge clk);
            lo <= rows[i].lo;
            hi <= rows[i].hi;
            next_word <= rows[i].code;
            repeat (6) @(posedge clk);
            #1;
            cmp("primary", prim, {1'b0, rows[i].code});
            cmp("complement", comp, 9'h0FF - {1'b0, rows[i].code});
            cmp("mode", 9'(mode), 9'(rows[i].mode));
            cmp("neg clock", 9'(neg), 9'(rows[i].mode != dacl_pkg::DACL_CLK_SINGLE));
        end
        // a new word every edge: each must come out four edges after the bench queues it
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            next_word <= 8'(i * 37);
            #1;
            if (i >= 4) cmp("stream", prim, {1'b0, 8'((i - 4) * 37)});
        end
        @(posedge clk);
        next_word <= 8'h5A;
        repeat (6) @(posedge clk);
        clk_en <= 1'b0;
        next_word <= 8'h3C;
        repeat (8) @(posedge clk);
        #1;
        cmp("held", prim, 9'h05A);
        @(posedge clk);
        clk_en <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        cmp("resumed", prim, 9'h03C);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        cmp("reset primary", prim, 9'h000);
        cmp("reset complement", comp, 9'h0FF);
        cmp("reset mode", 9'(mode), 9'(dacl_pkg::DACL_CLK_SINGLE));
        cmp("reset neg clock", 9'(neg), 9'h000);
        end_of_test();
    end
endmodule // dacl_latch_tb
`default_nettype wire

// ==== testbench/dacl_src.sv ====
/* sample source model: presents the word that the bench queues.
   assumes the bench hands it the next word at each rising edge. */
`timescale 1ns/1ns
`default_nettype none
module dacl_src (
    input  wire logic       clk,
    input  wire logic [7:0] next_word,
    output var  logic [7:0] sample_word
);
    initial sample_word = 8'h00;
    // change on the falling edge, away from the sampling edge
    always @(negedge clk) sample_word <= next_word; // bit 7 is the msb
endmodule // dacl_src
`default_nettype wire
